// ---- design/record_device_end.sv ----
// device end: request decoder with opcode table, reply fifo, response encoder
// assumes the search core answers in request order and holds its answer until taken
//
// How it works
// - unpack record, drive instruction, context, key to core
// - core answer returns index or data per table
// - per-table setting groups replies into packets
// - reply built only on matching count, good parity
// - count mismatch closes the open packet
// - parity error returns opcode 250 eight-byte error
// - entry: length, valid, mode, instruction fields
// - mode bit says context index is present
// - mode 0: table instruction, fixed context index
// - host payloads byte aligned, key at most 640
// - key is low length bytes of payload, less the two context bytes in mode 1
// - table write 4B/1B, table read 1B/4B
// - programmed write 24B request, 1B reply
// - programmed reads 4B request, 11B reply
// - no-operation 16B zeros, 1B reply
// - buffer write needs mode 1, 1B reply
// - compare record: key plus context, up to 82B
// - decode no-op and programmed instruction codes
// - group 010 compares, table from bits 9,5:0
// - group 100 low zero writes buffer at context
// - opcode zero is empty padding record
// - reply opcode copies request opcode, except 250 on parity error
// - host waits table write answer before reuse
`timescale 1ns/1ps
`include "record_layer_cfg.svh"
module record_device_end #(
    parameter int FIFO_DEPTH = 16,
    parameter logic [14:0] FIXED_CONTEXT = 15'h0000
) (
    input wire logic clk,
    input wire logic rst,
    record_link_if.dev link,
    output logic coreValid,
    input wire logic coreReady,
    output logic [9:0] coreInstr,
    output logic [15:0] coreContext,
    output logic [`KEY_BITS-1:0] coreKey,
    output logic [15:0] coreSeq,
    input wire logic coreRspValid,
    output logic coreRspReady,
    input wire logic [15:0] coreRspSeq,
    input wire logic [255:0] coreRspIndex,
    input wire logic [`RSP_PAYLOAD_BITS-1:0] coreRspData,
    input wire logic [7:0] coreRspLen,
    input wire logic [127:0] ltrReturnData,
    input wire logic [127:0] ltrOnePerPacket
);
    localparam int PW = $clog2(FIFO_DEPTH);

    record_layer_pkg::table_entry_t opTable [0:255];
    logic [7:0] fifoOp [0:FIFO_DEPTH-1];
    logic [15:0] fifoSeq [0:FIFO_DEPTH-1];
    logic [6:0] fifoLtr [0:FIFO_DEPTH-1];
    logic fifoPar [0:FIFO_DEPTH-1];
    logic [PW:0] wrPtr;
    logic [PW:0] rdPtr;
    logic fifoEmpty;
    logic fifoFull;

    record_layer_pkg::table_entry_t entry;
    logic [6:0] entLen;
    logic entMode;
    logic [9:0] entInstr;
    logic isFixed;
    logic toCore;
    logic localErr;
    logic [9:0] decInstr;
    logic [`REQ_PAYLOAD_BITS-1:0] keyMask;
    logic [`REQ_PAYLOAD_BITS-1:0] ctxShift;
    logic [15:0] decContext;
    logic [`REQ_PAYLOAD_BITS-1:0] decKey;
    logic takeReq;
    logic takeCoreRsp;
    logic [7:0] headOp;
    logic [15:0] headSeq;
    logic [6:0] headLtr;
    logic headParBad;

    assign fifoEmpty = (wrPtr == rdPtr);
    assign fifoFull = (wrPtr[PW-1:0] == rdPtr[PW-1:0]) && (wrPtr[PW] != rdPtr[PW]);
    assign headOp = fifoOp[rdPtr[PW-1:0]];
    assign headSeq = fifoSeq[rdPtr[PW-1:0]];
    assign headLtr = fifoLtr[rdPtr[PW-1:0]];
    assign headParBad = fifoPar[rdPtr[PW-1:0]] != ^{headOp, headSeq, headLtr};

    // table fields
    assign entry = opTable[link.reqOpcode];
    assign entLen = entry[`ENTRY_LEN_MSB:`ENTRY_LEN_LSB];
    assign entMode = entry[`ENTRY_MODE_BIT];
    assign entInstr = entry[`ENTRY_INSTR_MSB:`ENTRY_INSTR_LSB];
    assign isFixed = link.reqOpcode >= `OPC_ERROR;

    // key from the low length bytes of the payload, less the two context bytes in mode 1
    always_comb begin
        keyMask = '0;
        ctxShift = '0;
        decContext = {1'b0, FIXED_CONTEXT};
        if (isFixed) begin
            keyMask = ~'0 >> (`REQ_PAYLOAD_BITS - 8 * link.reqLen);
        end else if (entMode) begin
            // context sits in the two highest bytes of the record
            keyMask = ~'0 >> (`REQ_PAYLOAD_BITS + 16 - 8 * entLen);
            ctxShift = link.reqPayload >> (8 * entLen - 16);
            decContext = ctxShift[15:0];
        end else begin
            keyMask = ~'0 >> (`REQ_PAYLOAD_BITS - 8 * entLen);
        end
        decKey = link.reqPayload & keyMask;
    end

    // classify the record
    always_comb begin
        toCore = 1'b0;
        localErr = 1'b0;
        decInstr = entInstr;
        case (link.reqOpcode)
            `OPC_TABLE_WRITE, `OPC_TABLE_READ: toCore = 1'b0;
            `OPC_PROG_WRITE: begin
                toCore = 1'b1;
                decInstr = {1'b0, `INSTR_GRP_NONE, `INSTR_LOW_PROG_WRITE};
            end
            `OPC_PROG_READ_DATA: begin
                toCore = 1'b1;
                decInstr = {1'b0, `INSTR_GRP_NONE, `INSTR_LOW_PROG_READ_DATA};
            end
            `OPC_PROG_READ_MASK: begin
                toCore = 1'b1;
                decInstr = {1'b0, `INSTR_GRP_NONE, `INSTR_LOW_PROG_READ_MASK};
            end
            `OPC_ERROR: localErr = 1'b1;
            default: begin
                if (!entry[`ENTRY_VALID_BIT]) begin
                    localErr = 1'b1;
                end else if (entInstr == 10'h000) begin
                    toCore = 1'b0;
                end else if (entInstr[8:6] == `INSTR_GRP_BUF_WRITE) begin
                    toCore = entMode && entInstr[5:0] == `INSTR_LOW_NOP;
                    localErr = !toCore;
                end else if (entInstr[8:6] == `INSTR_GRP_COMPARE) begin
                    toCore = 1'b1;
                end else begin
                    toCore = entInstr[9:6] == 4'h0 && entInstr[5:0] <= `INSTR_LOW_PROG_READ_MASK;
                    localErr = !toCore;
                end
            end
        endcase
    end

    // local replies wait for the fifo to drain so reply order follows request order
    always_comb begin
        takeCoreRsp = coreRspValid && !link.rspValid;
        if (link.reqOpcode == `OPC_EMPTY) begin
            takeReq = link.reqValid;
        end else if (toCore) begin
            takeReq = link.reqValid && !coreValid && !fifoFull;
        end else begin
            takeReq = link.reqValid && !link.rspValid && fifoEmpty && !coreRspValid;
        end
    end
    assign link.reqReady = takeReq;
    assign coreRspReady = takeCoreRsp;

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 256; i++) begin
                opTable[i] <= `ENTRY_RESET;
            end
        end else if (takeReq && link.reqOpcode == `OPC_TABLE_WRITE) begin
            opTable[link.reqPayload[31:24]] <= link.reqPayload[18:0];
        end
    end

    // core request register
    always_ff @(posedge clk) begin
        if (rst) begin
            coreValid <= 1'b0;
            coreInstr <= '0;
            coreContext <= '0;
            coreKey <= '0;
            coreSeq <= '0;
        end else if (takeReq && toCore && link.reqOpcode != `OPC_EMPTY) begin
            coreValid <= 1'b1;
            coreInstr <= decInstr;
            coreContext <= decContext;
            coreKey <= decKey[`KEY_BITS-1:0];
            coreSeq <= link.reqSeq;
        end else if (coreReady) begin
            coreValid <= 1'b0;
        end
    end

    // reply fifo holds what each core answer must match
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (takeReq && toCore && link.reqOpcode != `OPC_EMPTY) begin
                fifoOp[wrPtr[PW-1:0]] <= link.reqOpcode;
                fifoSeq[wrPtr[PW-1:0]] <= link.reqSeq;
                fifoLtr[wrPtr[PW-1:0]] <= {decInstr[9], decInstr[5:0]};
                fifoPar[wrPtr[PW-1:0]] <= ^{link.reqOpcode, link.reqSeq, decInstr[9],
                    decInstr[5:0]};
                wrPtr <= wrPtr + 1'b1;
            end
            if (takeCoreRsp && !fifoEmpty) begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end

    // reply register
    always_ff @(posedge clk) begin
        if (rst) begin
            link.rspValid <= 1'b0;
            link.rspOpcode <= '0;
            link.rspSeq <= '0;
            link.rspLen <= '0;
            link.rspLast <= 1'b0;
            link.rspPayload <= '0;
            link.rspClose <= 1'b0;
        end else begin
            link.rspClose <= 1'b0;
            if (link.rspValid && link.rspReady) begin
                link.rspValid <= 1'b0;
            end
            if (takeCoreRsp) begin
                if (!fifoEmpty && headParBad) begin
                    link.rspValid <= 1'b1;
                    link.rspOpcode <= `OPC_ERROR;
                    link.rspSeq <= headSeq;
                    link.rspLen <= `LEN_ERROR_RSP;
                    link.rspLast <= 1'b1;
                    link.rspPayload <= {960'h0, headSeq, coreRspSeq, 24'h0, headOp};
                end else if (!fifoEmpty && headSeq == coreRspSeq) begin
                    link.rspValid <= 1'b1;
                    link.rspOpcode <= headOp;
                    link.rspSeq <= headSeq;
                    link.rspLen <= coreRspLen;
                    link.rspLast <= ltrOnePerPacket[headLtr];
                    link.rspPayload <= ltrReturnData[headLtr] ? coreRspData
                        : {768'h0, coreRspIndex};
                end else begin
                    link.rspClose <= 1'b1;
                end
            end else if (takeReq && !toCore && link.reqOpcode != `OPC_EMPTY) begin
                link.rspValid <= 1'b1;
                link.rspOpcode <= link.reqOpcode;
                link.rspSeq <= link.reqSeq;
                link.rspLast <= 1'b1;
                if (link.reqOpcode == `OPC_TABLE_READ) begin
                    link.rspLen <= `LEN_TABLE_READ_RSP;
                    link.rspPayload <= {992'h0, 8'h00, 5'h00,
                        opTable[link.reqPayload[7:0]]};
                end else begin
                    link.rspLen <= `LEN_STATUS_RSP;
                    link.rspPayload <= {1016'h0, 7'h00, localErr};
                end
            end
        end
    end
endmodule

// ---- design/record_layer_cfg.svh ----
// record layer constants: opcodes, table entry fields, lengths in bytes, payload widths in bits
// assumes it is included by bare name from the package and both ends
`ifndef RECORD_LAYER_CFG_SVH
`define RECORD_LAYER_CFG_SVH
`define OPC_EMPTY 8'h00
`define OPC_TABLE_WRITE 8'hFF
`define OPC_TABLE_READ 8'hFE
`define OPC_PROG_WRITE 8'hFD
`define OPC_PROG_READ_DATA 8'hFC
`define OPC_PROG_READ_MASK 8'hFB
`define OPC_ERROR 8'hFA
`define ENTRY_LEN_MSB 6
`define ENTRY_LEN_LSB 0
`define ENTRY_VALID_BIT 7
`define ENTRY_MODE_BIT 8
`define ENTRY_INSTR_MSB 18
`define ENTRY_INSTR_LSB 9
`define ENTRY_RESET 19'h00000
`define LEN_TABLE_WRITE_REQ 7'h04
`define LEN_TABLE_WRITE_RSP 8'h01
`define LEN_TABLE_READ_REQ 7'h01
`define LEN_TABLE_READ_RSP 8'h04
`define LEN_PROG_WRITE_REQ 7'h18
`define LEN_PROG_READ_REQ 7'h04
`define LEN_PROG_READ_RSP 8'h0B
`define LEN_STATUS_RSP 8'h01
`define LEN_ERROR_RSP 8'h08
`define LEN_REQ_MAX 7'h52
`define LEN_CONTEXT 7'h02
`define LEN_NOP_REQ 7'h10
`define INSTR_GRP_NONE 3'b000
`define INSTR_GRP_COMPARE 3'b010
`define INSTR_GRP_BUF_WRITE 3'b100
`define INSTR_LOW_NOP 6'h00
`define INSTR_LOW_PROG_WRITE 6'h01
`define INSTR_LOW_PROG_READ_DATA 6'h02
`define INSTR_LOW_PROG_READ_MASK 6'h03
`define REQ_PAYLOAD_BITS 656
`define RSP_PAYLOAD_BITS 1024
`define KEY_BITS 640
`endif

// ---- design/record_layer_pkg.sv ----
// record layer types shared by both ends
// assumes record_layer_cfg.svh is on the include path
`include "record_layer_cfg.svh"
package record_layer_pkg;
    typedef logic [18:0] table_entry_t;
    typedef logic [`REQ_PAYLOAD_BITS-1:0] req_payload_t;
    typedef logic [`RSP_PAYLOAD_BITS-1:0] rsp_payload_t;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b01,
        HOST_WAIT_TABLE = 2'b10
    } host_state_t;
endpackage

// ---- design/record_link_if.sv ----
// record-level link between host and device, framing already removed
// assumes one clock; payload bytes sit at [8*len-1:0], first byte highest
`timescale 1ns/1ps
interface record_link_if;
    logic reqValid;
    logic reqReady;
    logic [7:0] reqOpcode;
    logic [15:0] reqSeq;
    logic [6:0] reqLen;
    record_layer_pkg::req_payload_t reqPayload;
    logic rspValid;
    logic rspReady;
    logic [7:0] rspOpcode;
    logic [15:0] rspSeq;
    logic [7:0] rspLen;
    logic rspLast;
    record_layer_pkg::rsp_payload_t rspPayload;
    logic rspClose;
    modport dev (input reqValid, reqOpcode, reqSeq, reqLen, reqPayload, rspReady,
        output reqReady, rspValid, rspOpcode, rspSeq, rspLen, rspLast, rspPayload, rspClose);
    modport host (output reqValid, reqOpcode, reqSeq, reqLen, reqPayload, rspReady,
        input reqReady, rspValid, rspOpcode, rspSeq, rspLen, rspLast, rspPayload, rspClose);
endinterface

// ---- design/record_host_end.sv ----
// host end: numbers and sends request records, hands replies to the user
// assumes user lengths are in bytes and payload bytes sit low, first byte highest
`timescale 1ns/1ps
`include "record_layer_cfg.svh"
module record_host_end (
    input wire logic clk,
    input wire logic rst,
    record_link_if.host link,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [7:0] cmdOpcode,
    input wire logic [6:0] cmdLen,
    input wire logic [`REQ_PAYLOAD_BITS-1:0] cmdPayload,
    output logic cmdReject,
    output logic replyValid,
    output logic [7:0] replyOpcode,
    output logic [15:0] replySeq,
    output logic [7:0] replyLen,
    output logic replyLast,
    output logic replyError,
    output logic [`RSP_PAYLOAD_BITS-1:0] replyPayload,
    output logic packetClosed
);
    record_layer_pkg::host_state_t state;
    logic [15:0] nextSeq;
    logic badCmd;
    logic takeCmd;

    // fixed opcodes carry fixed lengths; 250 and empty are never requests
    always_comb begin
        case (cmdOpcode)
            `OPC_TABLE_WRITE: badCmd = cmdLen != `LEN_TABLE_WRITE_REQ;
            `OPC_TABLE_READ: badCmd = cmdLen != `LEN_TABLE_READ_REQ;
            `OPC_PROG_WRITE: badCmd = cmdLen != `LEN_PROG_WRITE_REQ;
            `OPC_PROG_READ_DATA, `OPC_PROG_READ_MASK: begin
                badCmd = cmdLen != `LEN_PROG_READ_REQ;
            end
            `OPC_ERROR, `OPC_EMPTY: badCmd = 1'b1;
            default: badCmd = cmdLen > `LEN_REQ_MAX || cmdLen == 7'h00;
        endcase
    end

    // a stalled table write blocks all traffic, which is stricter than needed
    assign cmdReady = state == record_layer_pkg::HOST_IDLE && (!link.reqValid || link.reqReady);
    assign takeCmd = cmdValid && cmdReady && !badCmd;
    assign link.rspReady = 1'b1;

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= record_layer_pkg::HOST_IDLE;
        end else begin
            case (state)
                record_layer_pkg::HOST_IDLE: begin
                    if (takeCmd && cmdOpcode == `OPC_TABLE_WRITE) begin
                        state <= record_layer_pkg::HOST_WAIT_TABLE;
                    end
                end
                record_layer_pkg::HOST_WAIT_TABLE: begin
                    if (link.rspValid && link.rspOpcode == `OPC_TABLE_WRITE) begin
                        state <= record_layer_pkg::HOST_IDLE;
                    end
                end
                default: state <= record_layer_pkg::HOST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            link.reqValid <= 1'b0;
            link.reqOpcode <= '0;
            link.reqSeq <= '0;
            link.reqLen <= '0;
            link.reqPayload <= '0;
            nextSeq <= '0;
            cmdReject <= 1'b0;
        end else begin
            cmdReject <= cmdValid && cmdReady && badCmd;
            if (link.reqValid && link.reqReady) begin
                link.reqValid <= 1'b0;
            end
            if (takeCmd) begin
                link.reqValid <= 1'b1;
                link.reqOpcode <= cmdOpcode;
                link.reqSeq <= nextSeq;
                link.reqLen <= cmdLen;
                link.reqPayload <= cmdPayload & (~'0 >> (`REQ_PAYLOAD_BITS - 8 * cmdLen));
                nextSeq <= nextSeq + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            replyValid <= 1'b0;
            replyOpcode <= '0;
            replySeq <= '0;
            replyLen <= '0;
            replyLast <= 1'b0;
            replyError <= 1'b0;
            replyPayload <= '0;
            packetClosed <= 1'b0;
        end else begin
            replyValid <= link.rspValid;
            packetClosed <= link.rspClose;
            if (link.rspValid) begin
                replyOpcode <= link.rspOpcode;
                replySeq <= link.rspSeq;
                replyLen <= link.rspLen;
                replyLast <= link.rspLast;
                replyError <= link.rspOpcode == `OPC_ERROR;
                replyPayload <= link.rspPayload;
            end
        end
    end
endmodule

// ---- testbench/record_link_checker.sv ----
// checker for the record link between the host and device ends
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`include "record_layer_cfg.svh"
module record_link_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic [7:0] reqOpcode,
    input wire logic [15:0] reqSeq,
    input wire logic [6:0] reqLen,
    input wire logic rspValid,
    input wire logic [7:0] rspOpcode,
    input wire logic [15:0] rspSeq,
    input wire logic [7:0] rspLen,
    input wire logic rspLast,
    input wire logic rspClose
);
    logic haveSeq;
    logic [15:0] lastSeq;
    wire logic take = reqValid && reqReady;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // first request after reset has no predecessor to compare against
    always_ff @(posedge clk) begin
        if (rst) begin
            haveSeq <= 1'b0;
            lastSeq <= 16'h0000;
        end else if (take) begin
            haveSeq <= 1'b1;
            lastSeq <= reqSeq;
        end
    end
    sequence s_take(op);
        take && reqOpcode == op;
    endsequence
    sequence s_local(op, len);
        rspValid && rspOpcode == op && rspLen == len && rspLast;
    endsequence
    property p_req_hold;
        reqValid && !reqReady |=> reqValid && $stable(reqOpcode) && $stable(reqSeq);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request moved early");
    property p_table_write;
        s_take(`OPC_TABLE_WRITE) |=> s_local(`OPC_TABLE_WRITE, `LEN_TABLE_WRITE_RSP)
            ##0 rspSeq == $past(reqSeq);
    endproperty
    a_table_write: assert property (p_table_write) else $error("bad write reply");
    property p_table_read;
        s_take(`OPC_TABLE_READ) |=> s_local(`OPC_TABLE_READ, `LEN_TABLE_READ_RSP)
            ##0 rspSeq == $past(reqSeq);
    endproperty
    a_table_read: assert property (p_table_read) else $error("bad read reply");
    property p_table_stall;
        s_take(`OPC_TABLE_WRITE) |=> !take [*2];
    endproperty
    a_table_stall: assert property (p_table_stall) else $error("no wait on write");
    property p_fixed_len;
        reqValid && reqOpcode == `OPC_TABLE_READ |-> reqLen == `LEN_TABLE_READ_REQ;
    endproperty
    a_fixed_len: assert property (p_fixed_len) else $error("bad read length");
    property p_pw_len;
        reqValid && reqOpcode == `OPC_PROG_WRITE |-> reqLen == `LEN_PROG_WRITE_REQ;
    endproperty
    a_pw_len: assert property (p_pw_len) else $error("bad write length");
    property p_pr_len;
        reqValid && reqOpcode inside {8'hFB, 8'hFC} |-> reqLen == `LEN_PROG_READ_REQ;
    endproperty
    a_pr_len: assert property (p_pr_len) else $error("bad read length");
    property p_error_len;
        rspValid && rspOpcode == `OPC_ERROR |-> rspLen == `LEN_ERROR_RSP;
    endproperty
    a_error_len: assert property (p_error_len) else $error("bad error length");
    property p_close_pulse;
        rspClose |=> !rspClose;
    endproperty
    a_close_pulse: assert property (p_close_pulse) else $error("close too long");
    property p_no_empty;
        reqValid |-> reqOpcode != `OPC_EMPTY && reqOpcode != `OPC_ERROR;
    endproperty
    a_no_empty: assert property (p_no_empty) else $error("reserved opcode sent");
    property p_seq_next;
        take && haveSeq |-> reqSeq == lastSeq + 16'h0001;
    endproperty
    a_seq_next: assert property (p_seq_next) else $error("sequence skipped");
endmodule

// ---- testbench/tb.sv ----
// testbench: host and device ends joined by the link, core side played here
// assumes the design package and config header are compiled first
`timescale 1ns/1ps
`include "record_layer_cfg.svh"
module tb;
    localparam logic [14:0] FIXED_CTX = 15'h2A5A;
    localparam logic [79:0] KEY = 80'hA1B2_C3D4_E5F6_0718_293A;
    localparam logic [191:0] PAY = 192'h0102030405060708090A0B0C0D0E0F101112131415161718;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmdValid = 1'b0, coreReady = 1'b0, coreRspValid = 1'b0;
    logic [7:0] cmdOpcode = 8'h00;
    logic [6:0] cmdLen = 7'h00;
    logic [`REQ_PAYLOAD_BITS-1:0] cmdPayload = '0;
    logic [15:0] coreRspSeq = 16'h0000;
    logic [`RSP_PAYLOAD_BITS-1:0] coreRspData = 1024'hCAFE_F00D;
    logic [127:0] ltrReturnData = 128'h8, ltrOnePerPacket = 128'h8;
    logic cmdReady, cmdReject, replyValid, replyLast, replyError, packetClosed;
    logic coreValid, coreRspReady;
    logic [7:0] replyOpcode, replyLen;
    logic [15:0] replySeq, coreContext, coreSeq, cCtx, expSeq = 16'h0000, sent;
    logic [9:0] coreInstr, cInstr;
    logic [`RSP_PAYLOAD_BITS-1:0] replyPayload;
    logic [`KEY_BITS-1:0] coreKey, cKey;
    logic [7:0] pOp [3] = '{8'hFD, 8'hFC, 8'hFB};
    logic [6:0] pLen [3] = '{7'h18, 7'h04, 7'h04};
    int num_errors = 0, tests_run = 0, k;
    record_link_if link ();
    record_host_end record_host_end_inst (.clk(clk), .rst(rst), .link(link.host),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOpcode(cmdOpcode), .cmdLen(cmdLen),
        .cmdPayload(cmdPayload), .cmdReject(cmdReject), .replyValid(replyValid),
        .replyOpcode(replyOpcode), .replySeq(replySeq), .replyLen(replyLen),
        .replyLast(replyLast), .replyError(replyError), .replyPayload(replyPayload),
        .packetClosed(packetClosed));
    record_device_end #(.FIFO_DEPTH(16), .FIXED_CONTEXT(FIXED_CTX)) record_device_end_inst (
        .clk(clk), .rst(rst), .link(link.dev), .coreValid(coreValid), .coreReady(coreReady),
        .coreInstr(coreInstr), .coreContext(coreContext), .coreKey(coreKey), .coreSeq(coreSeq),
        .coreRspValid(coreRspValid), .coreRspReady(coreRspReady), .coreRspSeq(coreRspSeq),
        .coreRspIndex(256'h77), .coreRspData(coreRspData), .coreRspLen(8'h04),
        .ltrReturnData(ltrReturnData), .ltrOnePerPacket(ltrOnePerPacket));
    record_link_checker record_link_checker_inst (.clk(clk), .rst(rst),
        .reqValid(link.reqValid), .reqReady(link.reqReady), .reqOpcode(link.reqOpcode),
        .reqSeq(link.reqSeq), .reqLen(link.reqLen), .rspValid(link.rspValid),
        .rspOpcode(link.rspOpcode), .rspSeq(link.rspSeq), .rspLen(link.rspLen),
        .rspLast(link.rspLast), .rspClose(link.rspClose));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string name, input logic [1023:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // refused commands must not consume a sequence number
    task automatic send(input logic [7:0] op, input logic [6:0] len,
            input logic [`REQ_PAYLOAD_BITS-1:0] pay, input logic bad);
        int i;
        @(negedge clk);
        cmdValid = 1'b1;
        cmdOpcode = op;
        cmdLen = len;
        cmdPayload = pay;
        #1;
        for (i = 0; i < 40 && cmdReady !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        cmdValid = 1'b0;
        check("cmdReject", cmdReject, bad);
        sent = expSeq;
        if (!bad) expSeq++;
    endtask
    task automatic get_reply(input logic expClose);
        int i;
        for (i = 0; i < 40 && (replyValid | packetClosed) !== 1'b1; i++) @(negedge clk);
        check("packetClosed", packetClosed, expClose);
        check("replyValid", replyValid, !expClose);
    endtask
    task automatic exp_rep(input logic [7:0] op, input logic [15:0] seq);
        check("replyOpcode", replyOpcode, op);
        check("replySeq", replySeq, seq);
    endtask
    // plays the core: takes one request, answers with its count or a corrupted one
    task automatic serve(input logic badSeq);
        int i;
        for (i = 0; i < 40 && coreValid !== 1'b1; i++) @(negedge clk);
        check("coreValid", coreValid, 1'b1);
        {cInstr, cCtx, cKey} = {coreInstr, coreContext, coreKey};
        coreReady = 1'b1;
        coreRspSeq = coreSeq ^ {badSeq, 15'h0000};
        @(negedge clk);
        coreReady = 1'b0;
        coreRspValid = 1'b1;
        #1;
        for (i = 0; i < 40 && coreRspReady !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        coreRspValid = 1'b0;
    endtask
    task automatic tw(input logic [7:0] addr, input logic [18:0] entry);
        send(`OPC_TABLE_WRITE, `LEN_TABLE_WRITE_REQ, {addr, 5'h00, entry}, 1'b0);
        get_reply(1'b0);
        exp_rep(`OPC_TABLE_WRITE, sent);
        check("replyLen", replyLen, `LEN_TABLE_WRITE_RSP);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        send(`OPC_TABLE_READ, 7'h01, 8'h05, 1'b0);
        get_reply(1'b0);
        check("tableRead", replyPayload[31:0], 32'h0);
        tw(8'h05, {10'h083, 1'b0, 1'b1, 7'h0A});
        send(`OPC_TABLE_READ, 7'h01, 8'h05, 1'b0);
        get_reply(1'b0);
        check("replyLen", replyLen, 8'h04);
        check("entry", replyPayload[31:0], {13'h0, 10'h083, 2'b01, 7'h0A});
        send(8'h05, 7'h0A, KEY, 1'b0);
        serve(1'b0);
        check("coreInstr", cInstr, 10'h083);
        check("coreContext", cCtx, {1'b0, FIXED_CTX});
        check("coreKey", cKey, KEY);
        get_reply(1'b0);
        exp_rep(8'h05, sent);
        check("replyData", replyPayload, coreRspData);
        check("replyLast", replyLast, 1'b1);
        send(8'h05, 7'h0A, KEY, 1'b0);
        serve(1'b1);
        get_reply(1'b1);
        send(8'h07, 7'h01, 8'h33, 1'b0);
        get_reply(1'b0);
        exp_rep(8'h07, sent);
        check("status", replyPayload[7:0], 8'h01);
        check("coreIdle", coreValid, 1'b0);
        tw(8'h09, {10'h100, 1'b1, 1'b1, 7'h0C});
        send(8'h09, 7'h0C, {16'hBEEF, KEY}, 1'b0);
        serve(1'b0);
        check("coreInstr", cInstr, 10'h100);
        check("coreContext", cCtx, 16'hBEEF);
        check("coreKey", cKey, KEY);
        get_reply(1'b0);
        exp_rep(8'h09, sent);
        check("replyIndex", replyPayload, 1024'h77);
        check("replyLast", replyLast, 1'b0);
        check("replyError", replyError, 1'b0);
        tw(8'h0A, {10'h100, 1'b0, 1'b1, 7'h0A});
        send(8'h0A, 7'h0A, KEY, 1'b0);
        get_reply(1'b0);
        check("status", replyPayload[7:0], 8'h01);
        tw(8'h0B, {10'h000, 1'b0, 1'b1, 7'h10});
        send(8'h0B, 7'h10, 128'h0, 1'b0);
        get_reply(1'b0);
        check("status", replyPayload[7:0], 8'h00);
        check("coreIdle", coreValid, 1'b0);
        for (k = 0; k < 3; k++) begin
            send(pOp[k], pLen[k], PAY, 1'b0);
            serve(1'b0);
            check("coreInstr", cInstr, 10'(k + 1));
            check("coreKey", cKey, PAY & ((192'h1 << (8 * pLen[k])) - 192'h1));
            get_reply(1'b0);
            exp_rep(pOp[k], sent);
        end
        send(`OPC_TABLE_WRITE, 7'h03, 32'h0, 1'b1);
        send(`OPC_ERROR, 7'h01, 8'h00, 1'b1);
        send(`OPC_EMPTY, 7'h01, 8'h00, 1'b1);
        send(8'h05, 7'h53, KEY, 1'b1);
        send(`OPC_TABLE_READ, 7'h01, 8'h05, 1'b0);
        get_reply(1'b0);
        exp_rep(`OPC_TABLE_READ, sent);
        finish_test();
    end
    // a full run takes well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule
